// *** logic/power_mode_clock_switch.v ***
// Purpose: Run, idle and sleep mode control with glitch-free system clock switching
// Assumes: Oscillator clocks and ready levels arrive asynchronously and are sampled on aclk
// Notes:   Registers reached over AXI4-Lite; only the low byte of each word is used
`include "power_mode_clock_switch_defines.vh"

// Summary of operation
// - Halt bit and source field pick mode
// - 00 primary, 01 secondary, 1x internal
// - Source change switches once source runs
// - Sleep: halt 0 sleeps, 1 idles
// - Each sleep uses current halt bit
// - Two old edges plus three new edges
// - Four flags report active clock source
// - Internal flag only when output stable
// - Internal-as-primary sets both primary flags
// - Reset starts primary run unless two-speed
// - Secondary select: switch, stop primary, flags
// - Force-on keeps secondary oscillator running
// - Secondary to primary waits primary ready
// - Upper bit set selects internal run
// - Frequency select changes speed immediately
// - Zero frequency, no hf: low-freq clock
// - Otherwise enable output, mf or hf flag
// - Clocks run while internal stabilises
// - Already stable internal keeps its flag
// - Internal to primary waits primary ready
// - Low-freq oscillator runs for watchdog, monitor
// - Sleep stops source, clears all flags
module power_mode_clock_switch (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire        sleep_exec,
  input  wire        wake_event,
  input  wire        two_speed_en,
  input  wire        internal_osc_is_primary,
  input  wire        primary_osc_clk,
  input  wire        secondary_osc_clk,
  input  wire        internal_osc_clk,
  input  wire        primary_osc_ready,
  input  wire        secondary_osc_ready,
  output reg  [2:0]  clk_gate_en,
  output reg         primary_osc_en,
  output reg         secondary_osc_en,
  output reg         internal_out_en,
  output reg         low_freq_osc_en,
  output reg  [2:0]  internal_freq,
  output reg         cpu_clk_en,
  output reg         periph_clk_en,
  output reg  [1:0]  power_state,
  output reg  [1:0]  active_source
);

  localparam integer INT_STABLE_CYC =
    (`INT_STABLE_NS * 1000 + `ACLK_PERIOD_PS - 1) / `ACLK_PERIOD_PS;
  localparam [15:0] INT_STABLE_LAST = INT_STABLE_CYC[15:0] - 16'h0001;
  localparam [7:0]  CTRL_RST        = `OSC_CONTROL_RST;
  localparam [1:0] ST_STEADY = 2'h0;
  localparam [1:0] ST_WAIT   = 2'h1;
  localparam [1:0] ST_OLD    = 2'h2;
  localparam [1:0] ST_NEW    = 2'h3;
  reg        halt_q;
  reg [2:0]  freq_q;
  reg [1:0]  scs_q;
  reg        force_q;
  reg        mf_sel_q;
  reg        hf_src_q;
  reg        wdt_q;
  reg        fscm_q;
  reg        pri_flag_q;
  reg        hf_flag_q;
  reg        mf_flag_q;
  reg        sec_flag_q;
  reg [1:0]  sw_st_q;
  reg [1:0]  tgt_q;
  reg [2:0]  edge_cnt_q;
  reg        sec_keep_q;
  reg [15:0] stab_cnt_q;
  reg        int_stable_q;
  reg        aw_hold_q;
  reg [7:0]  aw_addr_q;
  reg        w_hold_q;
  reg [7:0]  w_byte_q;
  reg        w_lane_q;
  // Three-stage samplers: pri clk, sec clk, int clk, pri ready, sec ready
  reg [4:0]  sync1_q;
  reg [4:0]  sync2_q;
  reg [4:0]  sync3_q;
  reg [4:0]  level_q;

  wire [4:0] agree_w    = ~(sync2_q ^ sync3_q);
  wire [4:0] level_d    = (agree_w & sync3_q) | (~agree_w & level_q);
  wire [4:0] rise_w     = level_d & ~level_q;
  wire [2:0] clk_edge_w = rise_w[2:0];
  wire int_en_w   = (freq_q != 3'h0) || hf_src_q;
  wire sleeping_w = (power_state == `PW_SLEEP);
  wire int_on_w   = int_en_w && !sleeping_w;
  wire busy_w     = (sw_st_q != ST_STEADY);
  wire [1:0] cur_w = active_source;
  // Source decode; lower bit ignored when upper bit set
  function [1:0] decode_src(input [1:0] scs);
    if (scs[1])
      decode_src = `SRC_INT;
    else if (scs[0])
      decode_src = `SRC_SEC;
    else
      decode_src = `SRC_PRI;
  endfunction
  // One edge flag per source; none for the stopped state
  function src_edge(input [1:0] src, input [2:0] edges);
    case (src)
      `SRC_PRI: src_edge = edges[0];
      `SRC_SEC: src_edge = edges[1];
      `SRC_INT: src_edge = edges[2];
      default:  src_edge = 1'b0;
    endcase
  endfunction
  function [1:0] reg_slot(input [7:0] addr);
    reg_slot = addr[3:2];
  endfunction
  function reg_hit(input [7:0] addr);
    reg_hit = (addr[7:4] == 4'h0);
  endfunction

  wire [1:0] target_w = sleeping_w ? `SRC_NONE : decode_src(scs_q);

  reg tgt_ready_w;
  always @* begin
    case (tgt_q)
      `SRC_PRI: tgt_ready_w = level_q[3];
      `SRC_SEC: tgt_ready_w = level_q[4] || force_q;
      `SRC_INT: tgt_ready_w = int_en_w ? int_stable_q : 1'b1;
      default:  tgt_ready_w = 1'b1;
    endcase
  end

  // Asynchronous input sampling
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      sync3_q <= 5'h00;
      level_q <= 5'h00;
    end else begin
      sync1_q <= {secondary_osc_ready, primary_osc_ready, internal_osc_clk,
                  secondary_osc_clk, primary_osc_clk};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  // Power mode: sleep instruction samples halt bit each time
  always @(posedge aclk) begin
    if (!aresetn) begin
      power_state <= `PW_RUN;
    end else if (wake_event && power_state != `PW_RUN) begin
      power_state <= `PW_RUN;
    end else if (sleep_exec && power_state == `PW_RUN) begin
      power_state <= halt_q ? `PW_IDLE : `PW_SLEEP;
    end
  end

  // Clock switch: release old source on its edges, then enable new on its edges
  always @(posedge aclk) begin
    if (!aresetn) begin
      sw_st_q       <= ST_STEADY;
      active_source <= two_speed_en ? `SRC_INT : `SRC_PRI;
      tgt_q         <= two_speed_en ? `SRC_INT : `SRC_PRI;
      clk_gate_en   <= two_speed_en ? 3'h4 : 3'h1;
      edge_cnt_q    <= 3'h0;
    end else if (target_w == `SRC_NONE) begin
      if (cur_w != `SRC_NONE) begin
        active_source <= `SRC_NONE;
        clk_gate_en   <= 3'h0;
      end
      sw_st_q    <= ST_STEADY;
      tgt_q      <= `SRC_NONE;
      edge_cnt_q <= 3'h0;
    end else begin
      case (sw_st_q)
        ST_STEADY: begin
          if (target_w != cur_w) begin
            tgt_q   <= target_w;
            sw_st_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          edge_cnt_q <= 3'h0;
          if (target_w != tgt_q)
            sw_st_q <= ST_STEADY;
          else if (tgt_ready_w)
            sw_st_q <= (cur_w == `SRC_NONE) ? ST_NEW : ST_OLD;
        end
        ST_OLD: begin
          if (src_edge(cur_w, clk_edge_w)) begin
            if (edge_cnt_q == `OLD_CLK_EDGES - 3'h1) begin
              clk_gate_en <= 3'h0;
              edge_cnt_q  <= 3'h0;
              sw_st_q     <= ST_NEW;
            end else
              edge_cnt_q <= edge_cnt_q + 3'h1;
          end
        end
        ST_NEW: begin
          if (src_edge(tgt_q, clk_edge_w)) begin
            if (edge_cnt_q == `NEW_CLK_EDGES - 3'h1) begin
              clk_gate_en   <= 3'h1 << tgt_q;
              active_source <= tgt_q;
              edge_cnt_q    <= 3'h0;
              sw_st_q       <= ST_STEADY;
            end else
              edge_cnt_q <= edge_cnt_q + 3'h1;
          end
        end
        default: sw_st_q <= ST_STEADY;
      endcase
    end
  end

  // Internal output stabilisation; device clocks keep running meanwhile
  always @(posedge aclk) begin
    if (!aresetn) begin
      stab_cnt_q   <= 16'h0000;
      int_stable_q <= 1'b0;
    end else if (!int_on_w) begin
      stab_cnt_q   <= 16'h0000;
      int_stable_q <= 1'b0;
    end else if (stab_cnt_q == INT_STABLE_LAST) begin
      int_stable_q <= 1'b1;
    end else begin
      stab_cnt_q <= stab_cnt_q + 16'h0001;
    end
  end

  // Status flags and oscillator enables
  wire int_flag_w = int_stable_q && int_en_w &&
                    (cur_w == `SRC_INT || (cur_w == `SRC_PRI && internal_osc_is_primary));

  always @(posedge aclk) begin
    if (!aresetn) begin
      pri_flag_q       <= !two_speed_en;
      hf_flag_q        <= 1'b0;
      mf_flag_q        <= 1'b0;
      sec_flag_q       <= 1'b0;
      sec_keep_q       <= 1'b0;
      primary_osc_en   <= 1'b1;
      secondary_osc_en <= 1'b0;
      internal_out_en  <= 1'b0;
      low_freq_osc_en  <= 1'b0;
      cpu_clk_en       <= 1'b1;
      periph_clk_en    <= 1'b1;
      internal_freq    <= 3'h0;
    end else begin
      pri_flag_q <= (cur_w == `SRC_PRI) && clk_gate_en[0];
      hf_flag_q  <= int_flag_w && !mf_sel_q;
      mf_flag_q  <= int_flag_w && mf_sel_q;
      sec_flag_q <= (cur_w == `SRC_SEC);
      if (cur_w == `SRC_SEC)
        sec_keep_q <= 1'b1;
      primary_osc_en   <= (cur_w == `SRC_PRI) || (busy_w && tgt_q == `SRC_PRI);
      secondary_osc_en <= force_q || sec_keep_q || (cur_w == `SRC_SEC) ||
                          (busy_w && tgt_q == `SRC_SEC);
      internal_out_en  <= int_on_w;
      low_freq_osc_en  <= wdt_q || fscm_q ||
                          (!int_en_w && (cur_w == `SRC_INT ||
                           (busy_w && tgt_q == `SRC_INT)));
      cpu_clk_en       <= (power_state == `PW_RUN) && (clk_gate_en != 3'h0);
      periph_clk_en    <= !sleeping_w && (clk_gate_en != 3'h0);
      internal_freq    <= freq_q;
    end
  end

  // AXI4-Lite write path
  assign awready = !aw_hold_q && !bvalid;
  assign wready  = !w_hold_q && !bvalid;
  wire   do_write_w = aw_hold_q && w_hold_q && !bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q  <= 1'b0;
      w_byte_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      halt_q    <= CTRL_RST[`CPU_HALT_BIT];
      freq_q    <= CTRL_RST[`FREQ_SEL_HI:`FREQ_SEL_LO];
      scs_q     <= CTRL_RST[`SRC_SEL_HI:`SRC_SEL_LO];
      force_q   <= 1'b0;
      mf_sel_q  <= 1'b0;
      hf_src_q  <= 1'b0;
      wdt_q     <= 1'b0;
      fscm_q    <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        w_byte_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (do_write_w) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= reg_hit(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
        if (reg_hit(aw_addr_q) && w_lane_q) begin
          case (reg_slot(aw_addr_q))
            2'h0: begin
              halt_q <= w_byte_q[`CPU_HALT_BIT];
              freq_q <= w_byte_q[`FREQ_SEL_HI:`FREQ_SEL_LO];
              scs_q  <= w_byte_q[`SRC_SEL_HI:`SRC_SEL_LO];
            end
            2'h1: begin
              mf_sel_q <= w_byte_q[`MF_SEL_BIT];
              force_q  <= w_byte_q[`SEC_FORCE_BIT];
            end
            2'h2: begin
              hf_src_q <= w_byte_q[`HF_SRC_BIT];
              wdt_q    <= w_byte_q[`WDT_EN_BIT];
              fscm_q   <= w_byte_q[`FSCM_EN_BIT];
            end
            default: ;
          endcase
        end
      end
    end
  end

  // AXI4-Lite read path
  assign arready = !rvalid;

  reg [7:0] rd_byte_w;
  always @* begin
    rd_byte_w = 8'h00;
    case (reg_slot(araddr))
      2'h0: begin
        rd_byte_w[`CPU_HALT_BIT]              = halt_q;
        rd_byte_w[`FREQ_SEL_HI:`FREQ_SEL_LO]  = freq_q;
        rd_byte_w[`PRI_FLAG_BIT]              = pri_flag_q;
        rd_byte_w[`HF_FLAG_BIT]               = hf_flag_q;
        rd_byte_w[`SRC_SEL_HI:`SRC_SEL_LO]    = scs_q;
      end
      2'h1: begin
        rd_byte_w[`SEC_FLAG_BIT]  = sec_flag_q;
        rd_byte_w[`MF_SEL_BIT]    = mf_sel_q;
        rd_byte_w[`SEC_FORCE_BIT] = force_q;
        rd_byte_w[`MF_FLAG_BIT]   = mf_flag_q;
      end
      2'h2: begin
        rd_byte_w[`HF_SRC_BIT]  = hf_src_q;
        rd_byte_w[`WDT_EN_BIT]  = wdt_q;
        rd_byte_w[`FSCM_EN_BIT] = fscm_q;
      end
      default: rd_byte_w = {2'h0, sw_st_q, power_state, active_source};
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= reg_hit(araddr) ? {24'h000000, rd_byte_w} : 32'h00000000;
      rresp  <= reg_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// *** logic/power_mode_clock_switch_defines.vh ***
// Purpose: Constants for the power-mode and system-clock switch block
// Assumes: 32-bit AXI4-Lite register port, 200 MHz bus clock
// Notes:   Register offsets are byte addresses
`ifndef POWER_MODE_CLOCK_SWITCH_DEFINES_VH
`define POWER_MODE_CLOCK_SWITCH_DEFINES_VH

// Register byte offsets
`define OSC_CONTROL_REG      8'h00
`define OSC_CONTROL_REG_TWO  8'h04
`define OSC_AUX_REG          8'h08
`define OSC_STATUS_REG       8'h0c

// osc_control_reg fields
`define CPU_HALT_BIT         7
`define FREQ_SEL_HI          6
`define FREQ_SEL_LO          4
`define PRI_FLAG_BIT         3
`define HF_FLAG_BIT          2
`define SRC_SEL_HI           1
`define SRC_SEL_LO           0

// osc_control_reg_two fields
`define SEC_FLAG_BIT         6
`define MF_SEL_BIT           4
`define SEC_FORCE_BIT        3
`define MF_FLAG_BIT          1

// osc_aux_reg fields
`define HF_SRC_BIT           0
`define WDT_EN_BIT           1
`define FSCM_EN_BIT          2

// Reset values
`define OSC_CONTROL_RST      8'h00
`define OSC_CONTROL_TWO_RST  8'h00
`define OSC_AUX_RST          8'h00

// Clock source codes
`define SRC_PRI              2'h0
`define SRC_SEC              2'h1
`define SRC_INT              2'h2
`define SRC_NONE             2'h3

// Power states
`define PW_RUN               2'h0
`define PW_IDLE              2'h1
`define PW_SLEEP             2'h2

// Switch timing, in edges of the outgoing and incoming clock
`define OLD_CLK_EDGES        3'h2
`define NEW_CLK_EDGES        3'h3

// Internal oscillator stabilisation time and bus clock period
`define INT_STABLE_NS        1000
`define ACLK_PERIOD_PS       5000

// AXI responses
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// *** bench/power_mode_clock_switch_chk.sv ***
// Purpose: Concurrent checks on the power-mode clock switch ports
// Assumes: Single aclk domain, synchronous active-low reset
// Notes:   Attached to every instance of the design by bind
module power_mode_clock_switch_chk (
  input logic       aclk,
  input logic       aresetn,
  input logic       sleep_exec,
  input logic       wake_event,
  input logic [2:0] clk_gate_en,
  input logic       secondary_osc_en,
  input logic       cpu_clk_en,
  input logic       periph_clk_en,
  input logic [1:0] power_state,
  input logic [1:0] active_source
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_gate_onehot: assert property ($onehot0(clk_gate_en))
    else $error("clock gates not one-hot");
  a_gate_source: assert property (clk_gate_en != 3'h0 |->
    clk_gate_en == (3'h1 << active_source)) else $error("gate differs from active source");
  a_sleep_taken: assert property (sleep_exec && !wake_event && power_state == 2'h0
    |=> power_state == 2'h1 || power_state == 2'h2) else $error("sleep request not taken");
  a_sleep_clear: assert property (power_state == 2'h2 && $past(power_state) == 2'h2
    |-> clk_gate_en == 3'h0 && active_source == 2'h3) else $error("sleep left a source on");
  a_idle_clocks: assert property (power_state == 2'h1 && $past(power_state) == 2'h1 &&
    $past(clk_gate_en) != 3'h0 |-> !cpu_clk_en && periph_clk_en)
    else $error("idle clock enables wrong");
  a_sleep_clocks: assert property (power_state == 2'h2 && $past(power_state) == 2'h2
    |-> !cpu_clk_en && !periph_clk_en) else $error("sleep clock enables wrong");
  a_run_clocks: assert property (power_state == 2'h0 && $past(power_state) == 2'h0 &&
    $past(clk_gate_en) != 3'h0 |-> cpu_clk_en && periph_clk_en)
    else $error("run clock enables wrong");
  a_sec_running: assert property (active_source == 2'h1 |-> secondary_osc_en)
    else $error("secondary source used while stopped");
  a_wake_run: assert property (wake_event && power_state != 2'h0 |=> power_state == 2'h0)
    else $error("wake did not return to run");
endmodule

bind power_mode_clock_switch power_mode_clock_switch_chk power_mode_clock_switch_chk_i (
  .aclk(aclk), .aresetn(aresetn), .sleep_exec(sleep_exec), .wake_event(wake_event),
  .clk_gate_en(clk_gate_en), .secondary_osc_en(secondary_osc_en), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .power_state(power_state), .active_source(active_source));

// *** bench/testbench.sv ***
// Purpose: Self-checking bench for the power-mode clock switch
// Assumes: Oscillators are slow square waves derived from aclk
// Notes:   Flags predicted from a small source and power model
`include "power_mode_clock_switch_defines.vh"
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        sleep_exec, wake_event, primary_osc_ready, secondary_osc_ready;
  logic        primary_osc_clk, secondary_osc_clk, internal_osc_clk, h;
  logic        two_speed_en, internal_osc_is_primary;
  logic [7:0]  awaddr, araddr, m_ctrl, m_two;
  logic [31:0] wdata, rd_d, lfsr;
  logic [3:0]  wstrb, ocnt;
  logic [2:0]  f;
  logic [1:0]  rd_r;
  wire         awready, wready, bvalid, arready, rvalid, primary_osc_en, secondary_osc_en;
  wire         internal_out_en, low_freq_osc_en, cpu_clk_en, periph_clk_en;
  wire  [1:0]  bresp, rresp, power_state, active_source;
  wire  [2:0]  clk_gate_en, internal_freq;
  wire  [31:0] rdata;
  int          bad_count, samples_checked, m_src, m_stable, m_pow;

  power_mode_clock_switch power_mode_clock_switch_i (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sleep_exec(sleep_exec), .wake_event(wake_event),
    .two_speed_en(two_speed_en), .internal_osc_is_primary(internal_osc_is_primary),
    .primary_osc_clk(primary_osc_clk),
    .secondary_osc_clk(secondary_osc_clk), .internal_osc_clk(internal_osc_clk),
    .primary_osc_ready(primary_osc_ready), .secondary_osc_ready(secondary_osc_ready),
    .clk_gate_en(clk_gate_en), .primary_osc_en(primary_osc_en),
    .secondary_osc_en(secondary_osc_en), .internal_out_en(internal_out_en),
    .low_freq_osc_en(low_freq_osc_en), .internal_freq(internal_freq), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .power_state(power_state), .active_source(active_source));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Oscillators well below aclk/4
  always @(posedge aclk) begin
    ocnt <= ocnt + 4'h1;
    primary_osc_clk <= ocnt[2];
    secondary_osc_clk <= ocnt[3];
    internal_osc_clk <= ocnt[2];
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 1000);
    `CHK("bresp", er, bresp)
    if (a == 8'h00 && er == `RESP_OKAY) m_ctrl = d;
    if (a == 8'h04 && er == `RESP_OKAY) m_two = d;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 1000);
    rd_d = rdata;
    rd_r = rresp;
  endtask

  task automatic chk_regs();
    logic on, pri, sec, io, hf, mf;
    on = (m_pow != 2);
    pri = on && m_src == 0;
    sec = on && m_src == 1;
    io = on && m_stable != 0 && (m_src == 2 || (m_src == 0 && internal_osc_is_primary));
    hf = io && !m_two[4];
    mf = io && m_two[4];
    rd(8'h00);
    `CHK("ctrl", {24'h0, m_ctrl[7:4], pri, hf, m_ctrl[1:0]}, rd_d)
    rd(8'h04);
    `CHK("ctrl_two", {24'h0, 1'b0, sec, 1'b0, m_two[4:3], 1'b0, mf, 1'b0}, rd_d)
  endtask

  task automatic wait_src(input int s);
    int n;
    n = 0;
    while (active_source !== s[1:0] && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    repeat (4) @(posedge aclk);
    m_src = s;
    `CHK("active_source", s[1:0], active_source)
  endtask

  task automatic pulse(input logic wake);
    if (wake) wake_event <= 1'b1;
    else sleep_exec <= 1'b1;
    @(posedge aclk);
    wake_event <= 1'b0;
    sleep_exec <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    $display("ERROR watchdog expected done seen timeout");
    summarize();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_exec, wake_event} = 8'h00;
    {two_speed_en, internal_osc_is_primary} = 2'h0;
    {primary_osc_clk, secondary_osc_clk, internal_osc_clk} = 3'h0;
    primary_osc_ready = 1'b1;
    secondary_osc_ready = 1'b0;
    {awaddr, araddr, wdata, wstrb, ocnt} = 56'h0;
    {bad_count, samples_checked, m_src, m_stable, m_pow} = 160'h0;
    {m_ctrl, m_two} = 16'h0;
    lfsr = 32'h6b44c93e;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_regs();
    rd(8'h0c);
    `CHK("status", 32'h0, rd_d)
    wr(8'h00, 8'h0c, `RESP_OKAY);
    chk_regs();
    rd(8'h10);
    `CHK("unmapped_read", {`RESP_SLVERR, 32'h0}, {rd_r, rd_d})
    wr(8'h14, 8'hff, `RESP_SLVERR);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      h = i[0];
      wr(8'h00, {h, 7'h0}, `RESP_OKAY);
      pulse(1'b0);
      m_pow = h ? 1 : 2;
      `CHK("power_state", m_pow[1:0], power_state)
      `CHK("clk_gate_en", h ? 3'h1 : 3'h0, clk_gate_en)
      chk_regs();
      pulse(1'b1);
      m_pow = 0;
      wait_src(0);
    end
    $display("test sleep and idle done");
    secondary_osc_ready <= 1'b1;
    wr(8'h00, 8'h01, `RESP_OKAY);
    wait_src(1);
    primary_osc_ready <= 1'b0;
    `CHK("primary_osc_en", 1'b0, primary_osc_en)
    chk_regs();
    wr(8'h00, 8'h00, `RESP_OKAY);
    repeat (40) @(posedge aclk);
    `CHK("held_on_secondary", 2'h1, active_source)
    primary_osc_ready <= 1'b1;
    wait_src(0);
    chk_regs();
    `CHK("secondary_osc_en", 1'b1, secondary_osc_en)
    secondary_osc_ready <= 1'b0;
    wr(8'h04, 8'h08, `RESP_OKAY);
    wr(8'h00, 8'h01, `RESP_OKAY);
    wait_src(1);
    wr(8'h00, 8'h00, `RESP_OKAY);
    wait_src(0);
    $display("test secondary done");
    wr(8'h00, 8'h03, `RESP_OKAY);
    wait_src(2);
    chk_regs();
    `CHK("internal_out_en", 1'b0, internal_out_en)
    `CHK("low_freq_osc_en", 1'b1, low_freq_osc_en)
    lfsr = nxt(lfsr);
    f = (lfsr[2:0] == 3'h0) ? 3'h1 : lfsr[2:0];
    wr(8'h00, {1'b0, f, 4'h2}, `RESP_OKAY);
    @(posedge aclk);
    `CHK("internal_freq", f, internal_freq)
    `CHK("internal_out_en", 1'b1, internal_out_en)
    chk_regs();
    repeat (220) @(posedge aclk);
    m_stable = 1;
    chk_regs();
    wr(8'h04, 8'h18, `RESP_OKAY);
    repeat (220) @(posedge aclk);
    chk_regs();
    wr(8'h00, {1'b0, f, 4'h0}, `RESP_OKAY);
    wait_src(0);
    chk_regs();
    wr(8'h00, {1'b0, f, 4'h2}, `RESP_OKAY);
    wait_src(2);
    chk_regs();
    $display("test internal done");
    two_speed_en <= 1'b1;
    internal_osc_is_primary <= 1'b1;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    {m_ctrl, m_two} = 16'h0;
    {m_stable, m_pow} = 64'h0;
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("two_speed_src", 2'h2, active_source)
    `CHK("two_speed_gate", 3'h4, clk_gate_en)
    wait_src(0);
    chk_regs();
    `CHK("low_freq_osc_en", 1'b0, low_freq_osc_en)
    wr(8'h08, 8'h02, `RESP_OKAY);
    @(posedge aclk);
    `CHK("low_freq_osc_en", 1'b1, low_freq_osc_en)
    wr(8'h00, 8'h10, `RESP_OKAY);
    repeat (220) @(posedge aclk);
    m_stable = 1;
    chk_regs();
    $display("test two-speed start done");
    summarize();
  end
endmodule
